// >>> hw/tx_sts3_telecom_bus_port.sv
// transmit side of the byte-wide sts-3 telecom bus
//
// Overview of operation
// - alarm high for each byte of an sts-1 flagged with ais-p in no-realign mode, else low
// - alarm active only when bus enabled and in no-realign mode
// - parity covers the eight data bits in the narrow setting
// - parity also covers payload indicator and frame marker in wide setting
// - parity coverage and polarity come from the bus control register
// - external alignment starts a frame at a sync rising edge
// - sync tied low gives free-running frame generation
// - sync delay register sets lag from sync edge to frame start
// - payload indicator low for each transport overhead byte
// - payload indicator high for every non-overhead byte
// - when enabled all outbound data leaves one byte at a time
// - all bus outputs update on the rising edge of the bus clock
// - marker pulses for c1 with payload low and j1 with payload high
`timescale 1ns/1ps
module tx_sts3_telecom_bus_port
  import tx_bus_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       REG_WR,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       TX_FRAME_SYNC_IN,
  input  wire logic [7:0] SRC_BYTE,
  output logic            SRC_TAKE,
  input  wire logic [2:0] AIS_P_IN,
  output logic            TX_BUS_CLOCK_OUT,
  output logic      [7:0] TX_BUS_BYTE_OUT,
  output logic            TX_PAYLOAD_INDICATOR,
  output logic            TX_FRAME_MARKER_OUT,
  output logic            TX_BUS_PARITY_OUT,
  output logic            TX_BUS_ALARM_OUT
);

  typedef struct packed {
    logic [7:0]  delay_reg;
    logic [7:0]  ctl_reg;
    logic [7:0]  rdata;
    logic        sync_meta;
    logic        sync_sync;
    logic        sync_prev;
    logic        sync_seen;
    logic [3:0]  div;
    logic        bus_clk;
    phase_type   phase;
    logic [7:0]  delay_cnt;
    logic [8:0]  col;
    logic [3:0]  row;
    logic [1:0]  sts;
    bus_out_type bus;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic        tick;
  logic        sync_rise;
  logic        start;
  logic [8:0]  col_e;
  logic [3:0]  row_e;
  logic [1:0]  sts_e;
  bus_out_type nxt;
  logic        enabled;

  assign enabled   = s_q.ctl_reg[CTL_ENABLE_BIT];
  assign tick      = (s_q.div == DIV_LAST);
  assign sync_rise = s_q.sync_sync & ~s_q.sync_prev;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d   = s_q;
    start = 1'b0;
    nxt   = BUS_OUT_RESET;
    col_e = s_q.col;
    row_e = s_q.row;
    sts_e = s_q.sts;
    SRC_TAKE = 1'b0;

    if (REG_WR && REG_ADDR == SYNC_DELAY_ADDR) begin
      s_d.delay_reg = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == BUS_CONTROL_ADDR) begin
      s_d.ctl_reg = REG_WDATA;
    end
    case (REG_ADDR)
      SYNC_DELAY_ADDR:  s_d.rdata = s_q.delay_reg;
      BUS_CONTROL_ADDR: s_d.rdata = s_q.ctl_reg;
      BUS_STATUS_ADDR:  s_d.rdata = {6'h00, s_q.sync_seen,
                                     s_q.phase == PH_DELAY};
      default:          s_d.rdata = 8'h00;
    endcase

    // sync pin is asynchronous here: two flops before any use
    s_d.sync_meta = TX_FRAME_SYNC_IN;
    s_d.sync_sync = s_q.sync_meta;
    s_d.sync_prev = s_q.sync_sync;

    s_d.div     = tick ? 4'h0 : 4'(s_q.div + 4'h1);
    s_d.bus_clk = (s_d.div < DIV_HALF); // rises with the output update

    // an edge is armed now, the frame starts once the delay runs out
    if (sync_rise && s_q.ctl_reg[CTL_EXT_ALIGN_BIT]) begin
      s_d.phase     = PH_DELAY;
      s_d.delay_cnt = s_q.delay_reg;
      s_d.sync_seen = 1'b1;
    end

    if (tick) begin
      case (s_q.phase)
        PH_DELAY: begin
          if (s_q.delay_cnt == 8'h00) begin
            start   = 1'b1;
            s_d.phase = PH_RUN;
          end else begin
            s_d.delay_cnt = 8'(s_q.delay_cnt - 8'h01);
          end
        end
        PH_RUN:  start = 1'b0;
        default: s_d.phase = PH_RUN;
      endcase
      if (start) begin
        col_e = 9'h000;
        row_e = 4'h0;
        sts_e = 2'h0;
      end

      // emit the byte at the effective position
      nxt.payload = (col_e >= TOH_COLS);
      nxt.marker  = (row_e == 4'h0) &&
                    (col_e == C1_COL || col_e == J1_COL);
      if (!nxt.payload) begin
        if (row_e == 4'h0 && col_e < A2_COL) begin
          nxt.data = A1_BYTE;
        end else if (row_e == 4'h0 && col_e < C1_COL) begin
          nxt.data = A2_BYTE;
        end else if (row_e == 4'h0 && col_e < C1_COL + 9'h003) begin
          nxt.data = {6'h00, 2'(sts_e + 2'h1)};
        end else begin
          nxt.data = 8'h00;
        end
      end else begin
        nxt.data = SRC_BYTE;
        SRC_TAKE = enabled;
      end
      nxt.alarm = AIS_P_IN[sts_e] &
                  s_q.ctl_reg[CTL_NO_REALIGN_BIT];
      nxt.parity = s_q.ctl_reg[CTL_WIDE_BIT] ?
                   ^{nxt.data, nxt.payload, nxt.marker}
                   : ^nxt.data;
      nxt.parity = nxt.parity ^ s_q.ctl_reg[CTL_ODD_BIT];
      if (!enabled) begin
        nxt = BUS_OUT_RESET;
      end
      s_d.bus = nxt;

      // free running wrap: 2430 byte periods per frame
      s_d.sts = (sts_e == STS_LAST) ? 2'h0 : 2'(sts_e + 2'h1);
      if (col_e == COL_LAST) begin
        s_d.col = 9'h000;
        s_d.row = (row_e == ROW_LAST) ? 4'h0 : 4'(row_e + 4'h1);
      end else begin
        s_d.col = 9'(col_e + 9'h001);
        s_d.row = row_e;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_q           <= '0;
      s_q.delay_reg <= SYNC_DELAY_RESET;
      s_q.ctl_reg   <= BUS_CONTROL_RESET;
      s_q.phase     <= PH_RUN;
      s_q.bus       <= BUS_OUT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA            = s_q.rdata;
  assign TX_BUS_CLOCK_OUT     = s_q.bus_clk;
  assign TX_BUS_BYTE_OUT      = s_q.bus.data;
  assign TX_PAYLOAD_INDICATOR = s_q.bus.payload;
  assign TX_FRAME_MARKER_OUT  = s_q.bus.marker;
  assign TX_BUS_PARITY_OUT    = s_q.bus.parity;
  assign TX_BUS_ALARM_OUT     = s_q.bus.alarm;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence bus_edge;
    !TX_BUS_CLOCK_OUT ##1 TX_BUS_CLOCK_OUT;
  endsequence

  // the byte on the pins was built one cycle back, from those settings
  sequence new_byte;
    bus_edge ##0 $past(enabled);
  endsequence

  a_outputs_hold: assert property (!$rose(TX_BUS_CLOCK_OUT) |->
    $stable({TX_BUS_BYTE_OUT, TX_PAYLOAD_INDICATOR, TX_FRAME_MARKER_OUT,
             TX_BUS_PARITY_OUT, TX_BUS_ALARM_OUT}))
    else $error("bus outputs moved off the bus clock edge");

  a_parity_narrow: assert property (new_byte ##0
    !$past(s_q.ctl_reg[CTL_WIDE_BIT]) |-> TX_BUS_PARITY_OUT ==
    (^TX_BUS_BYTE_OUT ^ $past(s_q.ctl_reg[CTL_ODD_BIT])))
    else $error("narrow parity wrong");

  a_parity_wide: assert property (new_byte ##0
    $past(s_q.ctl_reg[CTL_WIDE_BIT]) |-> TX_BUS_PARITY_OUT ==
    (^{TX_BUS_BYTE_OUT, TX_PAYLOAD_INDICATOR, TX_FRAME_MARKER_OUT}
     ^ $past(s_q.ctl_reg[CTL_ODD_BIT])))
    else $error("wide parity wrong");

  a_alarm_mode: assert property ($rose(TX_BUS_CLOCK_OUT) &&
    TX_BUS_ALARM_OUT |-> $past(enabled) &&
    $past(s_q.ctl_reg[CTL_NO_REALIGN_BIT]))
    else $error("alarm outside no-realign mode");

  a_alarm_ais: assert property (new_byte ##0
    $past(s_q.ctl_reg[CTL_NO_REALIGN_BIT]) |->
    TX_BUS_ALARM_OUT == $past(AIS_P_IN[sts_e]))
    else $error("alarm does not follow ais-p of the tributary");

  a_marker_pulse: assert property (bus_edge ##0
    TX_FRAME_MARKER_OUT |-> ##10 !TX_FRAME_MARKER_OUT)
    else $error("frame marker longer than one bus clock");

  a_sync_start: assert property (sync_rise &&
    s_q.ctl_reg[CTL_EXT_ALIGN_BIT] && s_q.delay_reg == 8'h00 |->
    ##[1:11] (s_q.col == 9'h001 && s_q.row == 4'h0))
    else $error("frame did not start after sync edge");

  a_toh_payload: assert property (new_byte ##0 enabled |->
    TX_PAYLOAD_INDICATOR ==
    (((s_q.col == 9'h000) ? COL_LAST : 9'(s_q.col - 9'h001)) >= TOH_COLS))
    else $error("payload indicator wrong for the column");

  a_take_tick: assert property (SRC_TAKE |-> tick && enabled)
    else $error("source byte taken off a byte period");

  a_free_wrap: assert property (tick && s_q.phase == PH_RUN &&
    s_q.col == COL_LAST && s_q.row == ROW_LAST |=> s_q.col == 9'h000
    && s_q.row == 4'h0)
    else $error("free-running frame did not wrap");

endmodule

// >>> hw/tx_bus_pkg.sv
// constants and types for the transmit telecom bus port
package tx_bus_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] SYNC_DELAY_ADDR   = 16'h0135;
  localparam logic [15:0] BUS_CONTROL_ADDR  = 16'h0137;
  localparam logic [15:0] BUS_STATUS_ADDR   = 16'h0138;
  localparam logic [7:0]  SYNC_DELAY_RESET  = 8'h00;
  localparam logic [7:0]  BUS_CONTROL_RESET = 8'h00;

  // control field positions
  localparam int CTL_ENABLE_BIT    = 0;
  localparam int CTL_ODD_BIT       = 1;
  localparam int CTL_WIDE_BIT      = 2;
  localparam int CTL_EXT_ALIGN_BIT = 3;
  localparam int CTL_NO_REALIGN_BIT = 4;

  // ****************************************
  // timing and frame geometry
  // ****************************************
  localparam int SYS_CLK_MHZ    = 200;
  localparam int BUS_CLK_MHZ    = 20;
  localparam int BUS_DIV        = SYS_CLK_MHZ / BUS_CLK_MHZ;
  localparam logic [3:0] DIV_LAST = 4'(BUS_DIV - 1);
  localparam logic [3:0] DIV_HALF = 4'(BUS_DIV / 2);
  localparam int FRAME_US       = 125;
  localparam int BYTE_RATE_MHZ_X100 = 1944;
  localparam int FRAME_BYTES    = FRAME_US * BYTE_RATE_MHZ_X100 / 100;
  localparam int ROW_BYTES      = 270;
  localparam logic [8:0] COL_LAST  = 9'(ROW_BYTES - 1);
  localparam logic [3:0] ROW_LAST  = 4'(FRAME_BYTES / ROW_BYTES - 1);
  localparam logic [8:0] TOH_COLS  = 9'h01B;
  localparam logic [8:0] A2_COL    = 9'h003;
  localparam logic [8:0] C1_COL    = 9'h006;
  localparam logic [8:0] J1_COL    = 9'h01B;
  localparam logic [1:0] STS_LAST  = 2'h2;
  localparam logic [7:0] A1_BYTE   = 8'hF6;
  localparam logic [7:0] A2_BYTE   = 8'h28;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PH_RUN   = 2'b01,
    PH_DELAY = 2'b10
  } phase_type;

  typedef struct packed {
    logic [7:0] data;
    logic       payload;
    logic       marker;
    logic       parity;
    logic       alarm;
  } bus_out_type;

  localparam bus_out_type BUS_OUT_RESET = '0;

endpackage

// >>> testbench/bus_sink.sv
// downstream telecom bus sink that tracks frame position
`timescale 1ns/1ps
module bus_sink
  import tx_bus_pkg::*;
(
  input  wire logic        bus_clk,
  input  wire bus_out_type bus,
  output bus_out_type      last,
  output int               col,
  output int               frames
);
  initial begin
    last = '0;
    col = 0;
    frames = 0;
  end
  // sample mid-byte, away from the update edge; a payload F6 is ignored
  always @(negedge bus_clk) begin
    last <= bus;
    if (bus.data == A1_BYTE && !bus.payload &&
        !(last.data == A1_BYTE && !last.payload)) begin
      col <= 0;
      frames <= frames + 1;
    end else begin
      col <= (col + 1) % ROW_BYTES;
    end
  end
endmodule

// >>> testbench/tb_tx_sts3_telecom_bus_port.sv
// testbench for the transmit telecom bus port
`timescale 1ns/1ps
module tb_tx_sts3_telecom_bus_port
  import tx_bus_pkg::*;
;
  localparam int LIMIT = 95000;
  logic        CLOCK = 0, RST = 1, REG_WR = 0, SYNC = 0, SRC_TAKE;
  logic [15:0] REG_ADDR = '0;
  logic [7:0]  REG_WDATA = '0, REG_RDATA, SRC_BYTE = '0, rd_v;
  logic [2:0]  AIS = 3'b010;
  logic        BCLK;
  wire bus_out_type bus;
  int          failures = 0, total_checks = 0, cyc = 0, st = 0, d0, d4;

  tx_sts3_telecom_bus_port i_tx_sts3_telecom_bus_port (
    .CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .TX_FRAME_SYNC_IN(SYNC), .SRC_BYTE(SRC_BYTE), .SRC_TAKE(SRC_TAKE),
    .AIS_P_IN(AIS), .TX_BUS_CLOCK_OUT(BCLK),
    .TX_BUS_BYTE_OUT(bus.data), .TX_PAYLOAD_INDICATOR(bus.payload),
    .TX_FRAME_MARKER_OUT(bus.marker), .TX_BUS_PARITY_OUT(bus.parity),
    .TX_BUS_ALARM_OUT(bus.alarm));
  bus_sink i_bus_sink (.bus_clk(BCLK), .bus(bus), .last(), .col(),
    .frames());

  always #2.5 CLOCK = ~CLOCK;
  always @(negedge CLOCK) if (SRC_TAKE === 1'b1) SRC_BYTE <= SRC_BYTE + 8'h01;
  // a hang ends the run here with a counted mismatch
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge CLOCK);
    REG_WR = 1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLOCK);
    REG_WR = 0;
  endtask
  task automatic rd(logic [15:0] a);
    @(negedge CLOCK);
    REG_ADDR = a;
    @(negedge CLOCK);
    rd_v = REG_RDATA;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // a disabled bus stays quiet even with odd parity and alarms asked for
  task automatic idle(logic [7:0] ctl);
    wr(BUS_CONTROL_ADDR, ctl);
    repeat (3 * BUS_DIV) @(negedge CLOCK);
    chk("idle data", 8'h00, bus.data);
    chk("idle bits", 8'h00, 8'(bus[3:0]));
    chk("idle take", 8'h00, 8'(SRC_TAKE));
  endtask
  task automatic regs;
    rd(SYNC_DELAY_ADDR);
    chk("delay rst", SYNC_DELAY_RESET, rd_v);
    rd(BUS_CONTROL_ADDR);
    chk("ctl rst", BUS_CONTROL_RESET, rd_v);
    rd(BUS_STATUS_ADDR);
    chk("status rst", 8'h00, rd_v);
    wr(SYNC_DELAY_ADDR, 8'h5A);
    rd(SYNC_DELAY_ADDR);
    chk("delay", 8'h5A, rd_v);
    wr(BUS_CONTROL_ADDR, 8'h16);
    rd(BUS_CONTROL_ADDR);
    chk("ctl", 8'h16, rd_v);
    wr(16'h0136, 8'hFF);
    rd(16'h0136);
    chk("unmapped", 8'h00, rd_v);
    idle(8'h00);
  endtask
  // one frame start and the first 30 bytes, free running with sync low
  task automatic walk(logic [7:0] ctl);
    int f, c;
    bus_out_type b;
    logic [7:0] e, p;
    wr(BUS_CONTROL_ADDR, ctl);
    f = i_bus_sink.frames;
    wait (i_bus_sink.frames != f);
    #1;
    if (st != 0)
      chk("period", 8'h01,
          8'(cyc - st == FRAME_BYTES * BUS_DIV));
    st = cyc;
    p = 8'h00;
    repeat (30) begin
      b = i_bus_sink.last;
      c = i_bus_sink.col;
      e = c < 3 ? A1_BYTE : c < 6 ? A2_BYTE : c < 9 ? 8'(c - 5) : 8'h00;
      if (c < 27) chk("data", e, b.data);
      // the source counts up once per byte taken
      if (c > 27) chk("payload data", 8'(p + 8'h01), b.data);
      p = b.data;
      chk("payload", 8'(c >= 27), 8'(b.payload));
      chk("marker", 8'(c == 6 || c == 27), 8'(b.marker));
      chk("parity",
          8'(^b.data ^ (ctl[CTL_WIDE_BIT] & (b.payload ^ b.marker))
             ^ ctl[CTL_ODD_BIT]), 8'(b.parity));
      chk("alarm",
          8'(AIS[c % 3] & ctl[CTL_NO_REALIGN_BIT] & ctl[CTL_ENABLE_BIT]),
          8'(b.alarm));
      @(negedge BCLK);
      #1;
    end
  endtask
  // cycles from a sync rise to the next detected frame start
  task automatic sync_lag(logic [7:0] d, output int dt);
    int f, n;
    wr(SYNC_DELAY_ADDR, d);
    @(posedge BCLK);
    @(negedge CLOCK);
    f = i_bus_sink.frames;
    SYNC = 1;
    for (n = 0; n < 400 && i_bus_sink.frames == f; n++) begin
      if (n == BUS_DIV) SYNC = 0;
      @(negedge CLOCK);
    end
    dt = n;
    while (n++ < BUS_DIV) @(negedge CLOCK);
    SYNC = 0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge CLOCK);
    RST = 0;
    regs();
    walk(8'h01);
    walk(8'h07);
    walk(8'h13);
    idle(8'h12);
    wr(BUS_CONTROL_ADDR, 8'h09);
    sync_lag(8'h00, d0);
    sync_lag(8'h04, d4);
    chk("sync lag", 8'h01, 8'(d0 < 4 * BUS_DIV));
    chk("delay lag", 8'(4 * BUS_DIV), 8'(d4 - d0));
    rd(BUS_STATUS_ADDR);
    chk("status", 8'h02, rd_v);
    report_and_stop();
  end
endmodule
